/* File: rtl/mie_regs.vh */
`ifndef MIE_REGS_VH
`define MIE_REGS_VH

`define MIE_ADDR_RX_START_DEMAND 32'hb00030a4
`define MIE_ADDR_MAX_RX_FRAME 32'hb00030a8
`define MIE_ADDR_IRQ_ENABLE 32'hb00030ac
`define MIE_ADDR_IRQ_STATUS 32'hb00030b0

`define MIE_MAX_RX_FRAME_RESET 16'h0800
`define MIE_MAX_RX_FRAME_MASK 32'h0000ffff
`define MIE_IRQ_ENABLE_RESET 32'h00000000
`define MIE_IRQ_ENABLE_MASK 32'h01ff4fff
`define MIE_IRQ_STATUS_MASK 32'h01fe4ffe

`define MIE_RX_MASTER_BIT 0
`define MIE_OVERSIZE_BIT 8
`define MIE_TX_MASTER_BIT 16
`define MIE_CRC_ERR_BIT 1
`define MIE_RX_OVERFLOW_BIT 2
`define MIE_FRAME_TOO_LONG_BIT 3
`define MIE_RX_GOOD_BIT 4
`define MIE_ALIGN_ERR_BIT 5
`define MIE_RUNT_FRAME_BIT 6
`define MIE_MISSED_FRAME_BIT 7
`define MIE_DMA_EARLY_NOTICE_BIT 9
`define MIE_RX_DESC_UNAVAIL_BIT 10
`define MIE_RX_BUS_ERR_BIT 11
`define MIE_CTRL_FRAME_RX_BIT 14
`define MIE_TX_UNDERFLOW_BIT 17
`define MIE_TX_COMPLETE_BIT 18
`define MIE_DEFER_EXCEED_BIT 19
`define MIE_NO_CARRIER_BIT 20
`define MIE_TX_ABORT_BIT 21
`define MIE_LATE_COLLISION_BIT 22
`define MIE_TX_DESC_UNAVAIL_BIT 23
`define MIE_TX_BUS_ERR_BIT 24
`define MIE_RX_SOURCES 32'h00004ffe
`define MIE_TX_SOURCES 32'h01fe0000

`endif

/* File: rtl/mie_status.v */
`timescale 1ns/100ps
// sticky event flags, cleared by writing one; a set in the clearing cycle wins
module mie_status #(
   parameter WIDTH = 32,
   parameter [WIDTH-1:0] VALID = {WIDTH{1'b1}}
) (
   input wire core_clk_in,
   input wire srst_in,
   input wire [WIDTH-1:0] set_in,
   input wire [WIDTH-1:0] clr_in,
   output wire [WIDTH-1:0] flags_out
);
   reg [WIDTH-1:0] flags_reg;
   wire [WIDTH-1:0] flags_next;

   assign flags_next = ((flags_reg & ~clr_in) | set_in) & VALID;
   assign flags_out = flags_reg;

   always @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         flags_reg <= {WIDTH{1'b0}};
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end
endmodule // mie_status

/* File: rtl/mie_top.v */
`timescale 1ns/100ps
`include "mie_regs.vh"

// Behaviour
// - any write to rx start demand releases a halted rx dma; otherwise ignored
// - 16-bit max rx frame length, writable, resets to 0x0800
// - frame longer than max with oversize enable sets oversize flag, and rx irq when rx master enable bit 0 is set
// - separate rx and tx interrupt outputs
// - tx master enable bit 16 gates every tx interrupt source
// - tx bus error and tx descriptor unavailable raise tx irq when enabled
// - late collision, tx abort, no carrier raise tx irq when enabled
// - defer exceed, tx complete, tx underflow raise tx irq when enabled
// - control frame rx and rx bus error raise rx irq when enabled
// - rx descriptor unavailable, dma early notice, oversize raise rx irq when enabled
// - rx master enable bit 0 gates every rx interrupt source
// - enable bit zero masks its flag, one lets it take part
// - writing one to a status bit clears it; zero leaves it
module mie_top #(
   parameter ADDR_WIDTH = 32,
   parameter LEN_WIDTH = 16
) (
   input wire core_clk_in,
   input wire srst_in,
   input wire [ADDR_WIDTH-1:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [31:0] reg_rdata_out,
   input wire [31:0] event_in,
   input wire rx_frame_done_in,
   input wire [LEN_WIDTH-1:0] rx_frame_len_in,
   input wire rx_dma_halted_in,
   output reg rx_restart_out,
   output reg [LEN_WIDTH-1:0] max_rx_frame_len_out,
   output reg rx_irq_out,
   output reg tx_irq_out
);
   reg [LEN_WIDTH-1:0] max_rx_frame_len_reg;
   reg [31:0] irq_enable_reg;
   reg [31:0] rdata_next;
   wire [31:0] irq_status;
   wire [31:0] status_set;
   wire [31:0] status_clr;
   wire oversize;
   wire wr_demand;
   wire wr_len;
   wire wr_en;
   wire wr_stat;
   wire rx_irq_next;
   wire tx_irq_next;
   // named enable fields
   wire rx_master_irq_en;
   wire crc_err_en;
   wire rx_overflow_en;
   wire frame_too_long_en;
   wire rx_good_en;
   wire align_err_en;
   wire runt_frame_en;
   wire missed_frame_en;
   wire oversize_frame_en;
   wire dma_early_notice_en;
   wire rx_desc_unavail_en;
   wire rx_bus_err_en;
   wire ctrl_frame_rx_en;
   wire tx_master_irq_en;
   wire tx_underflow_en;
   wire tx_complete_en;
   wire defer_exceed_en;
   wire no_carrier_en;
   wire tx_abort_en;
   wire late_collision_en;
   wire tx_desc_unavail_en;
   wire tx_bus_err_en;
   // named status flags
   wire crc_err_flag;
   wire rx_overflow_flag;
   wire frame_too_long_flag;
   wire rx_good_flag;
   wire align_err_flag;
   wire runt_frame_flag;
   wire missed_frame_flag;
   wire oversize_frame_flag;
   wire dma_early_notice_flag;
   wire rx_desc_unavail_flag;
   wire rx_bus_err_flag;
   wire ctrl_frame_rx_flag;
   wire tx_underflow_flag;
   wire tx_complete_flag;
   wire defer_exceed_flag;
   wire no_carrier_flag;
   wire tx_abort_flag;
   wire late_collision_flag;
   wire tx_desc_unavail_flag;
   wire tx_bus_err_flag;
   // flag and its own enable both set
   wire crc_err_hit;
   wire rx_overflow_hit;
   wire frame_too_long_hit;
   wire rx_good_hit;
   wire align_err_hit;
   wire runt_frame_hit;
   wire missed_frame_hit;
   wire oversize_frame_hit;
   wire dma_early_notice_hit;
   wire rx_desc_unavail_hit;
   wire rx_bus_err_hit;
   wire ctrl_frame_rx_hit;
   wire tx_underflow_hit;
   wire tx_complete_hit;
   wire defer_exceed_hit;
   wire no_carrier_hit;
   wire tx_abort_hit;
   wire late_collision_hit;
   wire tx_desc_unavail_hit;
   wire tx_bus_err_hit;
   // sources grouped as the interrupt rules group them
   wire tx_dma_pend;
   wire tx_line_pend;
   wire tx_frame_pend;
   wire rx_ctrl_pend;
   wire rx_dma_pend;
   wire rx_frame_pend;

   function hit;
      input [ADDR_WIDTH-1:0] addr;
      input [31:0] target;
      begin
         hit = (addr == target[ADDR_WIDTH-1:0]);
      end
   endfunction

   assign wr_demand = reg_wr_in & hit(reg_addr_in, `MIE_ADDR_RX_START_DEMAND);
   assign wr_len = reg_wr_in & hit(reg_addr_in, `MIE_ADDR_MAX_RX_FRAME);
   assign wr_en = reg_wr_in & hit(reg_addr_in, `MIE_ADDR_IRQ_ENABLE);
   assign wr_stat = reg_wr_in & hit(reg_addr_in, `MIE_ADDR_IRQ_STATUS);

   // length check is strict greater-than; a frame of exactly max is accepted
   assign oversize = rx_frame_done_in & (rx_frame_len_in > max_rx_frame_len_reg)
      & irq_enable_reg[`MIE_OVERSIZE_BIT];

   assign status_set = event_in | ({31'h0, oversize} << `MIE_OVERSIZE_BIT);
   assign status_clr = wr_stat ? reg_wdata_in : 32'h0;

   mie_status #(
      .WIDTH(32),
      .VALID(`MIE_IRQ_STATUS_MASK)
   ) u_status (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .set_in(status_set),
      .clr_in(status_clr),
      .flags_out(irq_status)
   );

   assign rx_master_irq_en = irq_enable_reg[`MIE_RX_MASTER_BIT];
   assign crc_err_en = irq_enable_reg[`MIE_CRC_ERR_BIT];
   assign rx_overflow_en = irq_enable_reg[`MIE_RX_OVERFLOW_BIT];
   assign frame_too_long_en = irq_enable_reg[`MIE_FRAME_TOO_LONG_BIT];
   assign rx_good_en = irq_enable_reg[`MIE_RX_GOOD_BIT];
   assign align_err_en = irq_enable_reg[`MIE_ALIGN_ERR_BIT];
   assign runt_frame_en = irq_enable_reg[`MIE_RUNT_FRAME_BIT];
   assign missed_frame_en = irq_enable_reg[`MIE_MISSED_FRAME_BIT];
   assign oversize_frame_en = irq_enable_reg[`MIE_OVERSIZE_BIT];
   assign dma_early_notice_en = irq_enable_reg[`MIE_DMA_EARLY_NOTICE_BIT];
   assign rx_desc_unavail_en = irq_enable_reg[`MIE_RX_DESC_UNAVAIL_BIT];
   assign rx_bus_err_en = irq_enable_reg[`MIE_RX_BUS_ERR_BIT];
   assign ctrl_frame_rx_en = irq_enable_reg[`MIE_CTRL_FRAME_RX_BIT];
   assign tx_master_irq_en = irq_enable_reg[`MIE_TX_MASTER_BIT];
   assign tx_underflow_en = irq_enable_reg[`MIE_TX_UNDERFLOW_BIT];
   assign tx_complete_en = irq_enable_reg[`MIE_TX_COMPLETE_BIT];
   assign defer_exceed_en = irq_enable_reg[`MIE_DEFER_EXCEED_BIT];
   assign no_carrier_en = irq_enable_reg[`MIE_NO_CARRIER_BIT];
   assign tx_abort_en = irq_enable_reg[`MIE_TX_ABORT_BIT];
   assign late_collision_en = irq_enable_reg[`MIE_LATE_COLLISION_BIT];
   assign tx_desc_unavail_en = irq_enable_reg[`MIE_TX_DESC_UNAVAIL_BIT];
   assign tx_bus_err_en = irq_enable_reg[`MIE_TX_BUS_ERR_BIT];

   assign crc_err_flag = irq_status[`MIE_CRC_ERR_BIT];
   assign rx_overflow_flag = irq_status[`MIE_RX_OVERFLOW_BIT];
   assign frame_too_long_flag = irq_status[`MIE_FRAME_TOO_LONG_BIT];
   assign rx_good_flag = irq_status[`MIE_RX_GOOD_BIT];
   assign align_err_flag = irq_status[`MIE_ALIGN_ERR_BIT];
   assign runt_frame_flag = irq_status[`MIE_RUNT_FRAME_BIT];
   assign missed_frame_flag = irq_status[`MIE_MISSED_FRAME_BIT];
   assign oversize_frame_flag = irq_status[`MIE_OVERSIZE_BIT];
   assign dma_early_notice_flag = irq_status[`MIE_DMA_EARLY_NOTICE_BIT];
   assign rx_desc_unavail_flag = irq_status[`MIE_RX_DESC_UNAVAIL_BIT];
   assign rx_bus_err_flag = irq_status[`MIE_RX_BUS_ERR_BIT];
   assign ctrl_frame_rx_flag = irq_status[`MIE_CTRL_FRAME_RX_BIT];
   assign tx_underflow_flag = irq_status[`MIE_TX_UNDERFLOW_BIT];
   assign tx_complete_flag = irq_status[`MIE_TX_COMPLETE_BIT];
   assign defer_exceed_flag = irq_status[`MIE_DEFER_EXCEED_BIT];
   assign no_carrier_flag = irq_status[`MIE_NO_CARRIER_BIT];
   assign tx_abort_flag = irq_status[`MIE_TX_ABORT_BIT];
   assign late_collision_flag = irq_status[`MIE_LATE_COLLISION_BIT];
   assign tx_desc_unavail_flag = irq_status[`MIE_TX_DESC_UNAVAIL_BIT];
   assign tx_bus_err_flag = irq_status[`MIE_TX_BUS_ERR_BIT];

   // a masked flag stays readable in status but never reaches an interrupt
   assign crc_err_hit = crc_err_flag & crc_err_en;
   assign rx_overflow_hit = rx_overflow_flag & rx_overflow_en;
   assign frame_too_long_hit = frame_too_long_flag & frame_too_long_en;
   assign rx_good_hit = rx_good_flag & rx_good_en;
   assign align_err_hit = align_err_flag & align_err_en;
   assign runt_frame_hit = runt_frame_flag & runt_frame_en;
   assign missed_frame_hit = missed_frame_flag & missed_frame_en;
   assign oversize_frame_hit = oversize_frame_flag & oversize_frame_en;
   assign dma_early_notice_hit = dma_early_notice_flag & dma_early_notice_en;
   assign rx_desc_unavail_hit = rx_desc_unavail_flag & rx_desc_unavail_en;
   assign rx_bus_err_hit = rx_bus_err_flag & rx_bus_err_en;
   assign ctrl_frame_rx_hit = ctrl_frame_rx_flag & ctrl_frame_rx_en;
   assign tx_underflow_hit = tx_underflow_flag & tx_underflow_en;
   assign tx_complete_hit = tx_complete_flag & tx_complete_en;
   assign defer_exceed_hit = defer_exceed_flag & defer_exceed_en;
   assign no_carrier_hit = no_carrier_flag & no_carrier_en;
   assign tx_abort_hit = tx_abort_flag & tx_abort_en;
   assign late_collision_hit = late_collision_flag & late_collision_en;
   assign tx_desc_unavail_hit = tx_desc_unavail_flag & tx_desc_unavail_en;
   assign tx_bus_err_hit = tx_bus_err_flag & tx_bus_err_en;

   // bits 12, 13 and 15 have no source and never take part
   assign tx_dma_pend = tx_bus_err_hit
      | tx_desc_unavail_hit;
   assign tx_line_pend = late_collision_hit
      | tx_abort_hit
      | no_carrier_hit;
   assign tx_frame_pend = defer_exceed_hit
      | tx_complete_hit
      | tx_underflow_hit;
   assign rx_ctrl_pend = ctrl_frame_rx_hit
      | rx_bus_err_hit;
   assign rx_dma_pend = rx_desc_unavail_hit
      | dma_early_notice_hit
      | oversize_frame_hit;
   assign rx_frame_pend = crc_err_hit
      | rx_overflow_hit
      | frame_too_long_hit
      | rx_good_hit
      | align_err_hit
      | runt_frame_hit
      | missed_frame_hit;

   assign tx_irq_next = tx_master_irq_en
      & (tx_dma_pend | tx_line_pend | tx_frame_pend);
   // rx sources are gated by the rx master enable, not the tx one
   assign rx_irq_next = rx_master_irq_en
      & (rx_ctrl_pend | rx_dma_pend | rx_frame_pend);

   always @*
   begin
      rdata_next = 32'h0;
      if (hit(reg_addr_in, `MIE_ADDR_MAX_RX_FRAME))
      begin
         rdata_next[LEN_WIDTH-1:0] = max_rx_frame_len_reg;
      end
      else if (hit(reg_addr_in, `MIE_ADDR_IRQ_ENABLE))
      begin
         rdata_next = irq_enable_reg;
      end
      else if (hit(reg_addr_in, `MIE_ADDR_IRQ_STATUS))
      begin
         rdata_next = irq_status;
         rdata_next[`MIE_TX_MASTER_BIT] = |(irq_status & `MIE_TX_SOURCES);
         rdata_next[`MIE_RX_MASTER_BIT] = |(irq_status & `MIE_RX_SOURCES);
      end
      else
      begin
         rdata_next = 32'h0;
      end
   end

   always @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         max_rx_frame_len_reg <= `MIE_MAX_RX_FRAME_RESET;
         irq_enable_reg <= `MIE_IRQ_ENABLE_RESET;
         reg_rdata_out <= 32'h0;
         rx_restart_out <= 1'b0;
         max_rx_frame_len_out <= `MIE_MAX_RX_FRAME_RESET;
         rx_irq_out <= 1'b0;
         tx_irq_out <= 1'b0;
      end
      else
      begin
         if (wr_len)
         begin
            max_rx_frame_len_reg <= reg_wdata_in[LEN_WIDTH-1:0];
         end
         if (wr_en)
         begin
            irq_enable_reg <= reg_wdata_in & `MIE_IRQ_ENABLE_MASK;
         end
         // demand register is write only and reads back zero
         reg_rdata_out <= reg_rd_in ? rdata_next : 32'h0;
         rx_restart_out <= wr_demand & rx_dma_halted_in;
         max_rx_frame_len_out <= max_rx_frame_len_reg;
         rx_irq_out <= rx_irq_next;
         tx_irq_out <= tx_irq_next;
      end
   end
endmodule // mie_top

/* File: tb/mie_monitor.sv */
`timescale 1ns/100ps
module mie_monitor #(
   parameter ADDR_WIDTH = 32,
   parameter LEN_WIDTH = 16
) (
   input wire core_clk_in,
   input wire srst_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire rx_frame_done_in,
   input wire rx_dma_halted_in,
   input wire rx_restart_out,
   input wire rx_irq_out,
   input wire tx_irq_out,
   input wire [ADDR_WIDTH-1:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire [31:0] reg_rdata_out,
   input wire [31:0] event_in,
   input wire [LEN_WIDTH-1:0] max_rx_frame_len_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   a_restart_pulse: assert property (reg_wr_in && reg_addr_in == 32'hb00030a4
      && rx_dma_halted_in |=> rx_restart_out) else $error("restart missing");
   a_restart_cause: assert property (rx_restart_out |-> $past(reg_wr_in)
      && $past(reg_addr_in) == 32'hb00030a4
      && $past(rx_dma_halted_in)) else $error("stray restart");
   a_len_copy: assert property (reg_wr_in && reg_addr_in == 32'hb00030a8 |-> ##2
      max_rx_frame_len_out == LEN_WIDTH'($past(reg_wdata_in, 2))) else $error("length copy");
   a_tx_rise: assert property ($rose(tx_irq_out) |->
      ($past(event_in, 2) & 32'h01fe0000) != 0 || $past(reg_wr_in, 2))
      else $error("tx irq cause");
   a_rx_rise: assert property ($rose(rx_irq_out) |->
      ($past(event_in, 2) & 32'h00004ffe) != 0 || $past(rx_frame_done_in, 2)
      || $past(reg_wr_in, 2)) else $error("rx irq cause");
   // an interrupt only drops through a status clear or an enable change
   a_tx_fall: assert property ($fell(tx_irq_out) |-> $past(reg_wr_in, 2))
      else $error("tx irq drop");
   a_rx_fall: assert property ($fell(rx_irq_out) |-> $past(reg_wr_in, 2))
      else $error("rx irq drop");
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 0)
      else $error("read data idle");
endmodule // mie_monitor
bind mie_top mie_monitor #(.ADDR_WIDTH(ADDR_WIDTH), .LEN_WIDTH(LEN_WIDTH)) mon (.core_clk_in,
   .srst_in, .reg_wr_in, .reg_rd_in, .rx_frame_done_in, .rx_dma_halted_in, .rx_restart_out,
   .rx_irq_out, .tx_irq_out, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .event_in,
   .max_rx_frame_len_out);

/* File: tb/mie_rx_dma.sv */
`timescale 1ns/100ps
// rx dma stand-in: halts on command, leaves halt only on a restart pulse
module mie_rx_dma (
   input wire core_clk_in,
   input wire halt_in,
   input wire restart_in,
   output logic halted_out = 1'b0
);
   always @(posedge core_clk_in)
      if (halt_in) halted_out <= 1'b1;
      else if (restart_in) halted_out <= 1'b0;
endmodule // mie_rx_dma

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
   localparam logic [31:0] A_RSD = 32'hb00030a4, A_LEN = 32'hb00030a8, A_EN = 32'hb00030ac;
   localparam logic [31:0] A_ST = 32'hb00030b0, SRC = 32'h01fe4ffe;
   logic core_clk_in = 0, srst_in = 1, reg_wr_in = 0, reg_rd_in = 0, done = 0, halt = 0;
   logic [31:0] reg_addr_in = 0, wd = 0, ev = 0, rdata;
   logic [15:0] flen = 0, mlen;
   logic rxi, txi, rp, halted;
   int num_errors = 0, n_tests = 0, cyc = 0;
   always #5 core_clk_in = ~core_clk_in;
   mie_top DUT (.core_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in(wd), .reg_wr_in,
      .reg_rd_in, .reg_rdata_out(rdata), .event_in(ev), .rx_frame_done_in(done),
      .rx_frame_len_in(flen), .rx_dma_halted_in(halted), .rx_restart_out(rp),
      .max_rx_frame_len_out(mlen), .rx_irq_out(rxi), .tx_irq_out(txi));
   mie_rx_dma dma (.core_clk_in, .halt_in(halt), .restart_in(rp), .halted_out(halted));
   task automatic chk(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, d);
      @(posedge core_clk_in) {reg_wr_in, reg_addr_in, wd} <= {1'b1, a, d};
      @(posedge core_clk_in) reg_wr_in <= 0;
   endtask
   task automatic rd(input logic [31:0] a, exp);
      @(posedge core_clk_in) {reg_rd_in, reg_addr_in} <= {1'b1, a};
      @(posedge core_clk_in) reg_rd_in <= 0;
      #1 chk(rdata, exp);
   endtask
   // irq lags the causing edge by one more register stage
   task automatic irq(input logic [1:0] exp);
      repeat (2) @(posedge core_clk_in);
      #1 chk({30'h0, rxi, txi}, {30'h0, exp});
   endtask
   task automatic t_regs;
      rd(A_LEN, 32'h800);
      rd(A_EN, 0);
      wr(A_LEN, 32'hffff1234);
      rd(A_LEN, 32'h1234);
      chk({16'h0, mlen}, 32'h1234);
      wr(A_EN, '1);
      rd(A_EN, 32'h01ff4fff);
      rd(32'hb00030c0, 0);
   endtask
   task automatic t_src;
      int m;
      for (int b = 1; b < 25; b++)
         if (SRC[b])
         begin
            m = b > 16 ? 16 : 0;
            wr(A_EN, 1 << m);
            @(posedge core_clk_in) ev <= 1 << b;
            @(posedge core_clk_in) ev <= 0;
            irq(0);
            rd(A_ST, 1 << b | 1 << m);
            wr(A_EN, 1 << b);
            irq(0);
            wr(A_EN, 1 << b | 1 << m);
            irq(b > 16 ? 2'b01 : 2'b10);
            wr(A_ST, 1 << b);
            irq(0);
            rd(A_ST, 0);
         end
   endtask
   task automatic t_len;
      // limit just above a standard frame, the only use the check is meant for
      wr(A_LEN, 32'h600);
      wr(A_EN, 32'h1);
      @(posedge core_clk_in) {done, flen} <= {1'b1, 16'h601};
      @(posedge core_clk_in) done <= 0;
      rd(A_ST, 0);
      wr(A_EN, 32'h101);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge core_clk_in) {done, flen} <= {1'b1, 16'h600 + i[15:0]};
         @(posedge core_clk_in) done <= 0;
         irq(i ? 2'b10 : 2'b00);
      end
      wr(A_ST, 0);
      irq(2'b10);
      wr(A_ST, 32'h100);
      irq(0);
   endtask
   task automatic t_rst;
      @(posedge core_clk_in) halt <= 1;
      @(posedge core_clk_in) halt <= 0;
      wr(A_RSD, 32'h5a5a5a5a);
      #1 chk(32'(rp), 1);
      wr(A_RSD, 0);
      #1 chk(32'(rp), 0);
      rd(A_RSD, 0);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge core_clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         final_report;
      end
   end
   initial
   begin
      repeat (10) @(posedge core_clk_in);
      srst_in <= 0;
      t_regs;
      t_src;
      t_len;
      t_rst;
      final_report;
   end
endmodule // tb
